// ### baud_gen_map.svh
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   offsets chosen for this block
`ifndef BAUD_GEN_MAP_SVH
`define BAUD_GEN_MAP_SVH
`define OFS_DIV_LOWER    12'h000
`define OFS_DIV_UPPER    12'h004
`define OFS_CONTROL      12'h008
`define OFS_STATUS       12'h00c
`define CTRL_SYNC_BIT    0
`define CTRL_DOUBLE_BIT  1
`define CTRL_POL_BIT     2
`define DIV_LOWER_RESET  8'h00
`define DIV_UPPER_RESET  4'h0
`define BASE_NORMAL      5'h10
`define BASE_DOUBLE      5'h08
`define BASE_SYNC        5'h02
`endif

// ### baud_gen_pkg.sv
// Purpose: types shared by the baud generator
// Assumes: nothing
// Notes:   apb request travels as one struct
package baud_gen_pkg;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;
	typedef enum logic [1:0] {
		MODE_ASYNC,
		MODE_SYNC
	} mode_type;
endpackage

// ### usart_baud_rate_generator.sv
// Purpose: baud prescaler and synchronous clock edge selection
// Assumes: apb slave with zero wait states; pready always high
// Notes:   tick pulses once per bit; sync clock toggles each half bit
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`include "baud_gen_map.svh"
module usart_baud_rate_generator #(
	// divisor width; prescaler and status word are laid out for 12 bits
	parameter int DIV_WIDTH = 12
) (
	// apb bus
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire baud_gen_pkg::apb_req_type  apb_req,
	output logic                            pready,
	output logic                            pslverr,
	output logic [31:0]                     prdata,
	// bit timing
	output logic                            bit_tick,
	output logic                            sync_serial_clock,
	output logic                            tx_change_strobe,
	output logic                            rx_sample_strobe
);
	import baud_gen_pkg::*;

	// refuse widths the fixed register split cannot hold
	if (DIV_WIDTH != 12) begin : g_width_check
		$error("divisor width must be 12");
	end

	logic [7:0]  baud_divisor_lower_reg;
	logic [3:0]  baud_divisor_upper_reg;
	logic        sync_mode_reg;
	logic        double_speed_reg;
	logic        sync_clock_polarity_reg;
	logic [11:0] prescale_reg;
	logic [4:0]  base_reg;
	logic [11:0] baud_divisor;
	logic        wr_access;
	logic        rd_access;
	logic        known_addr;
	logic        prescale_zero;
	logic        base_wrap;
	logic        half_tick;

	// full 12-bit divisor from both halves
	assign baud_divisor = {baud_divisor_upper_reg, baud_divisor_lower_reg};
	assign wr_access = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd_access = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
	assign known_addr = (apb_req.paddr == `OFS_DIV_LOWER) |
		(apb_req.paddr == `OFS_DIV_UPPER) |
		(apb_req.paddr == `OFS_CONTROL) | (apb_req.paddr == `OFS_STATUS);

	// base count per mode; double speed ignored in sync mode
	function automatic logic [4:0] base_of(input logic sync_m,
		input logic dbl);
		if (sync_m) begin
			return `BASE_SYNC;
		end
		return dbl ? `BASE_DOUBLE : `BASE_NORMAL;
	endfunction

	// divisor registers; upper bits never stored so they read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_divisor_lower_reg <= `DIV_LOWER_RESET;
			baud_divisor_upper_reg <= `DIV_UPPER_RESET;
		end else if (wr_access) begin
			if (apb_req.paddr == `OFS_DIV_LOWER) begin
				baud_divisor_lower_reg <= apb_req.pwdata[7:0];
			end
			if (apb_req.paddr == `OFS_DIV_UPPER) begin
				baud_divisor_upper_reg <= apb_req.pwdata[3:0];
			end
		end
	end

	// control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_mode_reg           <= 1'b0;
			double_speed_reg        <= 1'b0;
			sync_clock_polarity_reg <= 1'b0;
		end else if (wr_access && apb_req.paddr == `OFS_CONTROL) begin
			sync_mode_reg           <= apb_req.pwdata[`CTRL_SYNC_BIT];
			double_speed_reg        <= apb_req.pwdata[`CTRL_DOUBLE_BIT];
			sync_clock_polarity_reg <= apb_req.pwdata[`CTRL_POL_BIT];
		end
	end

	// read data captured in setup so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready  <= 1'b1;
		end else begin
			pready  <= 1'b1;
			pslverr <= apb_req.psel & ~apb_req.penable & ~known_addr;
			if (rd_access) begin
				case (apb_req.paddr)
				`OFS_DIV_LOWER: prdata <= {24'h00_0000,
					baud_divisor_lower_reg};
				`OFS_DIV_UPPER: prdata <= {28'h000_0000,
					baud_divisor_upper_reg};
				`OFS_CONTROL: prdata <= {29'h0000_0000,
					sync_clock_polarity_reg, double_speed_reg,
					sync_mode_reg};
				`OFS_STATUS: prdata <= {15'h0000, base_reg,
					prescale_reg};
				default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// prescaler counts divisor down to zero; zero divisor ticks every clock
	assign prescale_zero = (prescale_reg == 12'h000);
	assign base_wrap = prescale_zero &&
		(base_reg == 5'(base_of(sync_mode_reg, double_speed_reg) - 5'h01));
	assign half_tick = prescale_zero && sync_mode_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_reg <= 12'h000;
		end else if (wr_access && apb_req.paddr == `OFS_DIV_LOWER) begin
			// reload at once, dropping the running count
			prescale_reg <= {baud_divisor_upper_reg,
				apb_req.pwdata[7:0]};
		end else if (prescale_zero) begin
			prescale_reg <= baud_divisor;
		end else begin
			prescale_reg <= prescale_reg - 12'h001;
		end
	end

	// base counter splits each bit into 16, 8 or 2 prescaler periods
	// a mode change restarts the count: a count left above the new base
	// would otherwise run on to the 5-bit wrap and stretch one bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_reg <= 5'h00;
		end else if (wr_access && apb_req.paddr == `OFS_DIV_LOWER) begin
			base_reg <= 5'h00;
		end else if (wr_access && apb_req.paddr == `OFS_CONTROL) begin
			base_reg <= 5'h00;
		end else if (base_wrap) begin
			base_reg <= 5'h00;
		end else if (prescale_zero) begin
			base_reg <= base_reg + 5'h01;
		end
	end

	// bit tick and sync clock; polarity picks launch and sample edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_tick          <= 1'b0;
			sync_serial_clock <= 1'b0;
			tx_change_strobe  <= 1'b0;
			rx_sample_strobe  <= 1'b0;
		end else begin
			bit_tick <= base_wrap;
			tx_change_strobe <= 1'b0;
			rx_sample_strobe <= 1'b0;
			if (!sync_mode_reg) begin
				sync_serial_clock <= sync_clock_polarity_reg;
			end else if (half_tick) begin
				sync_serial_clock <= ~sync_serial_clock;
				// launch edge when clock sat at the polarity level: rising for polarity 0, falling for 1
				if (sync_serial_clock == sync_clock_polarity_reg) begin
					tx_change_strobe <= 1'b1;
				end else begin
					rx_sample_strobe <= 1'b1;
				end
			end
		end
	end

	AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		$past(rd_access && apb_req.paddr == `OFS_DIV_UPPER) |->
		prdata[31:4] == 28'h0) else $error("upper bits not zero");
	AST_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
		wr_access && apb_req.paddr == `OFS_DIV_LOWER |=>
		prescale_reg == $past({baud_divisor_upper_reg,
		apb_req.pwdata[7:0]})) else $error("no reload");
	AST_ZERO_DIV: assert property (@(posedge pclk) disable iff (!presetn)
		baud_divisor == 12'h0 && !wr_access |=> prescale_reg == 12'h0)
		else $error("zero divisor not max rate");
	AST_SYNC_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
		sync_mode_reg && half_tick |=> sync_serial_clock !=
		$past(sync_serial_clock)) else $error("no toggle");
	AST_POL_TX: assert property (@(posedge pclk) disable iff (!presetn)
		tx_change_strobe |-> sync_serial_clock != sync_clock_polarity_reg
		|| $changed(sync_clock_polarity_reg)) else $error("bad tx edge");
	// an expired count must reload the full 12-bit divisor
	AST_DIV_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
		prescale_zero && !wr_access |=>
		prescale_reg == $past(baud_divisor))
		else $error("prescaler reload wrong");
	AST_BASE: assert property (@(posedge pclk) disable iff (!presetn)
		!sync_mode_reg && !double_speed_reg && base_wrap |->
		base_reg == 5'h0f) else $error("bad async base");
	AST_DOUBLE: assert property (@(posedge pclk) disable iff (!presetn)
		!sync_mode_reg && double_speed_reg |-> base_reg < 5'h08 ||
		$past(!double_speed_reg) || $past(sync_mode_reg))
		else $error("bad double base");
	COV_TICK: cover property (@(posedge pclk) bit_tick);
	COV_TX: cover property (@(posedge pclk) tx_change_strobe);
	COV_RX: cover property (@(posedge pclk) rx_sample_strobe);
	// double speed ticks and a prescaler reload by software
	COV_DOUBLE: cover property (@(posedge pclk)
		double_speed_reg && bit_tick);
	COV_RELOAD: cover property (@(posedge pclk)
		wr_access && apb_req.paddr == `OFS_DIV_LOWER);
endmodule

// ### usart_baud_rate_generator_tb.sv
// Purpose: self-checking bench for the baud generator
// Assumes: apb slave answers when pready is high at an edge
// Notes:   periods are measured between ticks, past the first one
`timescale 1ns/100ps
`include "baud_gen_map.svh"
module usart_baud_rate_generator_tb;
	import baud_gen_pkg::*;
	logic        pclk, presetn, pready, pslverr, err;
	logic        bit_tick, sync_serial_clock, txs, rxs;
	logic [31:0] prdata, rd;
	apb_req_type apb_req;
	int          num_errors, samples_checked, n, c;

	usart_baud_rate_generator usart_baud_rate_generator_inst (
		.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
		.pready(pready), .pslverr(pslverr), .prdata(prdata),
		.bit_tick(bit_tick), .sync_serial_clock(sync_serial_clock),
		.tx_change_strobe(txs), .rx_sample_strobe(rxs));

	// compare one value and count it
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; an idle edge after it keeps drivers single-step
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		@(posedge pclk);
	endtask
	// cycles up to the next tick, bounded
	task automatic tick(output int k);
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (bit_tick !== 1'b1 && k < 5000);
	endtask
	// set mode and divisor, then compare the period with the model
	task automatic run(input int d, input int ctl);
		bus(1, `OFS_CONTROL, ctl);
		bus(1, `OFS_DIV_UPPER, d >> 8);
		bus(1, `OFS_DIV_LOWER, d & 255);
		tick(c);
		tick(c);
		tick(c);
		chk("period", c, (d + 1) * (ctl[0] ? 2 : ctl[1] ? 8 : 16));
	endtask
	// level of the sync clock just after a strobe
	task automatic lvl(input bit tx, input logic exp);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((tx ? txs : rxs) !== 1'b1 && n < 100);
		@(posedge pclk);
		chk(tx ? "tx_edge" : "rx_edge", sync_serial_clock, exp);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// free-running system clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// watchdog well past the expected run length
	initial begin
		#900000;
		num_errors++;
		summarize();
	end
	// main sequence
	initial begin
		presetn = 1'b0;
		apb_req = '0;
		err = 1'b0;
		void'($urandom(32'hc94b));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		bus(0, `OFS_DIV_LOWER, 0);
		chk("lower_rst", rd, 32'h0);
		bus(0, `OFS_DIV_UPPER, 0);
		chk("upper_rst", rd, 32'h0);
		bus(1, `OFS_DIV_UPPER, 32'hff);
		bus(0, `OFS_DIV_UPPER, 0);
		chk("upper_rsv", rd, 32'h0f);
		bus(1, `OFS_DIV_LOWER, 32'h1ff);
		bus(0, `OFS_DIV_LOWER, 0);
		chk("lower_w", rd, 32'hff);
		bus(0, 12'h010, 0);
		chk("unmapped_err", err, 1'b1);
		chk("unmapped_rd", rd, 32'h0);
		$display("test registers done");
		// zero divisor in every mode, then random divisors
		run(0, 0);
		run(0, 2);
		run(0, 1);
		for (int i = 0; i < 8; i++)
			run($urandom_range(63), i % 4);
		run(259, 0);
		$display("test rates done");
		// a long count must not delay the new divisor
		bus(1, `OFS_DIV_LOWER, 200);
		bus(1, `OFS_DIV_UPPER, 0);
		bus(1, `OFS_DIV_LOWER, 2);
		tick(c);
		chk("reload", c < 50, 1'b1);
		$display("test reload done");
		for (int p = 0; p < 2; p++) begin
			run(3, 1 | p << 2);
			lvl(1'b1, !p);
			lvl(1'b0, p[0]);
		end
		$display("test polarity done");
		summarize();
	end
endmodule
